// *** srh_params.svh ***
// Summary of operation
// - Write strobe stays high during reads
// - Read cycle lasts at least 10 ns
// - Cycles timed from stable address onward
// - Address setup 0 ns, cycle 10 ns
// - Strobe low 9 ns, 8 with drive off
// - Data set 5 ns before write end
// - Select-ended write needs 8 ns low
// - Host never drives while memory drives
// - Read address valid as select falls
`ifndef SRH_PARAMS_SVH
`define SRH_PARAMS_SVH
`define SRH_CLK_PS 4000
`define SRH_T_RC_PS 10000
`define SRH_T_AA_PS 10000
`define SRH_T_WC_PS 10000
`define SRH_T_WP_PS 8000
`define SRH_T_DW_PS 5000
`define SRH_T_HZ_PS 5000
`define SRH_CEIL(t) (((t) + `SRH_CLK_PS - 1) / `SRH_CLK_PS)
// Three capture stages plus the agreement register
`define SRH_SYNC_CYC 4
// Data lands after the access time, then must cross the whole capture
`define SRH_RD_CYC (`SRH_T_AA_PS / `SRH_CLK_PS + 1 + `SRH_SYNC_CYC)
`define SRH_WC_CYC `SRH_CEIL(`SRH_T_WC_PS)
`define SRH_WP_CYC `SRH_CEIL(`SRH_T_WP_PS)
`define SRH_DW_CYC `SRH_CEIL(`SRH_T_DW_PS)
`define SRH_HZ_CYC `SRH_CEIL(`SRH_T_HZ_PS)
// Strobe low: memory release wait, then the data setup time
`define SRH_WR_CYC (`SRH_HZ_CYC + `SRH_DW_CYC)
`define SRH_CNT_W 4
`define SRH_ADDR_W 17
`define SRH_DATA_W 8
`define SRH_CNT_ONE 4'h1
`define SRH_CNT_ZERO 4'h0
`define SRH_ADDR_ZERO 17'h00000
`define SRH_DATA_ZERO 8'h00
`define SRH_SYNC_ZERO 3'h0
`endif

// *** srh_pkg.sv ***
`include "srh_params.svh"
package srh_pkg;
   // One-hot sequencer states
   typedef enum logic [4:0] {
      SRH_IDLE = 5'h01,
      SRH_RD = 5'h02,
      SRH_WR = 5'h04,
      SRH_WEND = 5'h08,
      SRH_GAP = 5'h10
   } srh_state_e;
   typedef logic [`SRH_CNT_W-1:0] srh_cnt_t;
endpackage : srh_pkg

// *** srh_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Raw pin lanes in, settled lanes out
interface srh_sync_if;
   logic [7:0] raw;
   logic [7:0] clean;
   modport src (output raw, input clean);
   modport snk (input raw, output clean);
endinterface : srh_sync_if
`default_nettype wire

// *** srh_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "srh_params.svh"
// Three-stage capture of the shared lanes
module srh_sync (
   input wire logic i_mclk,
   input wire logic i_resetn,
   srh_sync_if.snk s
);
   logic [7:0] st1_r; // Metastable stage, read only by st2
   logic [7:0] st2_r;
   logic [7:0] st3_r;
   logic [7:0] clean_r;
   logic [7:0] clean_nxt;
   // Accept a value once stages two and three agree
   always_comb begin
      clean_nxt = clean_r;
      if (st2_r == st3_r) begin
         clean_nxt = st3_r;
      end
   end
   // Stage registers
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         st1_r <= `SRH_DATA_ZERO;
         st2_r <= `SRH_DATA_ZERO;
         st3_r <= `SRH_DATA_ZERO;
         clean_r <= `SRH_DATA_ZERO;
      end else begin
         st1_r <= s.raw;
         st2_r <= st1_r;
         st3_r <= st2_r;
         clean_r <= clean_nxt;
      end
   end
   assign s.clean = clean_r;
endmodule : srh_sync
`default_nettype wire

// *** srh_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "srh_params.svh"
// Host sequencer for a 128K x 8 asynchronous static memory
module srh_host (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_req, // Request pulse or level, taken when ready
   input wire logic i_we, // High for write
   input wire logic [16:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic o_ready,
   output logic o_rvalid,
   output logic [7:0] o_rdata,
   output logic [16:0] o_mem_addr,
   output logic o_mem_cs_n,
   output logic o_mem_oe_n,
   output logic o_mem_we_n,
   output logic [7:0] o_shared_bus_lanes_o,
   output logic o_shared_bus_lanes_oe,
   input wire logic [7:0] i_shared_bus_lanes_i
);
   srh_pkg::srh_state_e state_r, state_nxt;
   srh_pkg::srh_cnt_t cnt_r, cnt_nxt;
   logic [16:0] addr_r, addr_nxt;
   logic [7:0] wdat_r, wdat_nxt;
   logic [7:0] rdat_r, rdat_nxt;
   logic cs_n_r, cs_n_nxt;
   logic oe_n_r, oe_n_nxt;
   logic we_n_r, we_n_nxt;
   logic drv_r, drv_nxt;
   logic rv_r, rv_nxt;
   logic rdy_r, rdy_nxt;
   // Every check runs on the sequencer clock and rests in reset
   default clocking cb_chk @(posedge i_mclk);
   endclocking
   default disable iff (!i_resetn);
   srh_sync_if sif ();
   // Read data passes the three-stage capture
   assign sif.raw = i_shared_bus_lanes_i;
   srh_sync u_sync (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .s(sif.snk)
   );
   // Counter decrement, used in several states
   function automatic srh_pkg::srh_cnt_t dec(input srh_pkg::srh_cnt_t c);
      dec = (c == `SRH_CNT_ZERO) ? `SRH_CNT_ZERO : c - `SRH_CNT_ONE;
   endfunction : dec
   // Next-state and pin values
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = dec(cnt_r);
      addr_nxt = addr_r;
      wdat_nxt = wdat_r;
      rdat_nxt = rdat_r;
      cs_n_nxt = cs_n_r;
      oe_n_nxt = oe_n_r;
      we_n_nxt = we_n_r;
      drv_nxt = drv_r;
      rv_nxt = 1'b0;
      rdy_nxt = rdy_r;
      unique case (state_r)
         srh_pkg::SRH_IDLE: begin
            if (i_req && rdy_r) begin
               // Address set on the same edge that select falls
               addr_nxt = i_addr;
               wdat_nxt = i_wdata;
               cs_n_nxt = 1'b0;
               rdy_nxt = 1'b0;
               if (i_we) begin
                  // Drive enable stays high, so the 8 ns pulse applies
                  we_n_nxt = 1'b0;
                  oe_n_nxt = 1'b1;
                  cnt_nxt = srh_pkg::srh_cnt_t'(`SRH_WR_CYC);
                  state_nxt = srh_pkg::SRH_WR;
               end else begin
                  // Strobe held high for the whole read
                  we_n_nxt = 1'b1;
                  oe_n_nxt = 1'b0;
                  cnt_nxt = srh_pkg::srh_cnt_t'(`SRH_RD_CYC);
                  state_nxt = srh_pkg::SRH_RD;
               end
            end
         end
         srh_pkg::SRH_RD: begin
            // Wait access time plus capture latency
            if (cnt_r == `SRH_CNT_ONE) begin
               rdat_nxt = sif.clean;
               rv_nxt = 1'b1;
               cs_n_nxt = 1'b1;
               oe_n_nxt = 1'b1;
               cnt_nxt = srh_pkg::srh_cnt_t'(`SRH_HZ_CYC);
               state_nxt = srh_pkg::SRH_GAP;
            end
         end
         srh_pkg::SRH_WR: begin
            // Memory may still drive after strobe falls; wait it out,
            // then leave the data a full setup time before the strobe
            if (cnt_r == srh_pkg::srh_cnt_t'(`SRH_DW_CYC + 1)) begin
               drv_nxt = 1'b1;
            end
            if (cnt_r == `SRH_CNT_ONE) begin
               we_n_nxt = 1'b1;
               state_nxt = srh_pkg::SRH_WEND;
            end
         end
         srh_pkg::SRH_WEND: begin
            // Data and select removed after strobe rises, hold is 0
            drv_nxt = 1'b0;
            cs_n_nxt = 1'b1;
            cnt_nxt = srh_pkg::srh_cnt_t'(`SRH_HZ_CYC);
            state_nxt = srh_pkg::SRH_GAP;
         end
         srh_pkg::SRH_GAP: begin
            // Bus turnaround before the next cycle
            if (cnt_r <= `SRH_CNT_ONE) begin
               rdy_nxt = 1'b1;
               state_nxt = srh_pkg::SRH_IDLE;
            end
         end
         default: begin
            state_nxt = srh_pkg::SRH_IDLE;
            cs_n_nxt = 1'b1;
            oe_n_nxt = 1'b1;
            we_n_nxt = 1'b1;
            drv_nxt = 1'b0;
            rdy_nxt = 1'b1;
         end
      endcase
   end
   // State registers
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_r <= srh_pkg::SRH_IDLE;
         cnt_r <= `SRH_CNT_ZERO;
         addr_r <= `SRH_ADDR_ZERO;
         wdat_r <= `SRH_DATA_ZERO;
         rdat_r <= `SRH_DATA_ZERO;
         cs_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         we_n_r <= 1'b1;
         drv_r <= 1'b0;
         rv_r <= 1'b0;
         rdy_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         addr_r <= addr_nxt;
         wdat_r <= wdat_nxt;
         rdat_r <= rdat_nxt;
         cs_n_r <= cs_n_nxt;
         oe_n_r <= oe_n_nxt;
         we_n_r <= we_n_nxt;
         drv_r <= drv_nxt;
         rv_r <= rv_nxt;
         rdy_r <= rdy_nxt;
      end
   end
   assign o_ready = rdy_r;
   assign o_rvalid = rv_r;
   assign o_rdata = rdat_r;
   assign o_mem_addr = addr_r;
   assign o_mem_cs_n = cs_n_r;
   assign o_mem_oe_n = oe_n_r;
   assign o_mem_we_n = we_n_r;
   assign o_shared_bus_lanes_o = wdat_r;
   assign o_shared_bus_lanes_oe = drv_r;
   // Checks
   // Strobe falls with select already low
   sequence s_wr_start;
      $fell(we_n_r) && !cs_n_r;
   endsequence
   // Drive enable falls with the strobe high
   sequence s_rd_start;
      $fell(oe_n_r) && we_n_r;
   endsequence
   // Strobe rises, closing the write window
   sequence s_wr_end;
      $rose(we_n_r);
   endsequence
   // Host lanes only while the memory is told to stay off
   chk_no_contend: assert property (drv_r |-> oe_n_r)
      else $error("host drives during read");
   // Strobe stays high while the drive enable is low
   chk_rd_strobe: assert property (!oe_n_r |-> we_n_r)
      else $error("strobe low in read");
   // Read held for at least the cycle time
   chk_rd_len: assert property (s_rd_start |-> !oe_n_r [*4])
      else $error("read too short");
   // Strobe low long enough for a full pulse
   chk_wp_len: assert property (s_wr_start |-> !we_n_r [*3])
      else $error("write pulse short");
   // Shorter pulse figure only holds with drive enable high
   chk_wr_oe_high: assert property (!we_n_r |-> oe_n_r)
      else $error("drive enable low in write");
   // Data on the lanes two cycles before the strobe rises
   chk_data_setup: assert property (s_wr_end |-> $past(drv_r, 2))
      else $error("data setup short");
   // Data still driven as the strobe rises; hold is zero
   chk_data_hold: assert property (s_wr_end |-> drv_r)
      else $error("data dropped early");
   // Address frozen while selected
   chk_addr_stable: assert property (!cs_n_r && !$fell(cs_n_r)
      |-> $stable(addr_r)) else $error("address moved in cycle");
   // Answer is a single pulse, with the memory already deselected
   chk_rvalid_once: assert property (rv_r |-> ##1 !rv_r ##0 cs_n_r)
      else $error("read answer wrong");
   // Host waits out the memory's release before driving
   chk_drv_late: assert property (s_wr_start |-> !drv_r [*2])
      else $error("drove before release");
   // Select stays low well past the write window's minimum
   chk_cs_write: assert property (s_wr_start |-> !cs_n_r [*3])
      else $error("select short in write");
   // Idle means deselected and lanes released
   chk_idle_quiet: assert property (rdy_r |-> cs_n_r && !drv_r)
      else $error("busy pins while idle");
   // Answer comes after access time plus the capture latency
   chk_rd_answer: assert property (s_rd_start |-> ##7 rv_r)
      else $error("read answer late");
endmodule : srh_host
`default_nettype wire

// *** srh_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behavioural 128K x 8 static memory standing where the real part sits
module srh_mem_model (
   input wire logic [16:0] i_addr,
   input wire logic i_cs_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [7:0] i_lanes, // Resolved shared lanes
   input wire logic i_slow, // High gives the slowest legal access
   output logic [7:0] o_lanes,
   output logic o_drive // High while the memory drives
);
   logic [7:0] mem [0:131071];
   logic rd; // Read mode decode
   logic wr; // Write window decode
   initial begin
      o_lanes = 8'h5A;
      o_drive = 1'b0;
   end
   // Read only with select and drive enable low, strobe high
   assign rd = !i_cs_n && !i_oe_n && i_we_n;
   // Store only inside the select and strobe overlap, whatever the drive enable
   assign wr = !i_cs_n && !i_we_n;
   // Store as the window closes, when lanes and address have settled;
   // a level store could catch the old address at the window's opening
   always @(negedge wr) begin
      mem[i_addr] = i_lanes;
   end
   // Garbage until a slow access ends, so an early sampler sees wrong data
   always @(rd or i_addr) begin
      if (rd) begin
         o_drive <= #3 1'b1;
         o_lanes <= #3 ~mem[i_addr];
         o_lanes <= #(i_slow ? 10 : 3) mem[i_addr];
      end else begin
         // Released lanes do not keep the last value
         o_drive <= #1 1'b0;
         o_lanes <= #1 ~o_lanes;
      end
   end
endmodule : srh_mem_model
`default_nettype wire

// *** srh_host_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the static memory host sequencer
module srh_host_test;
   logic i_mclk, i_resetn, i_req, i_we, slow, cs_q;
   logic [16:0] i_addr, m_addr, a_q;
   logic [7:0] i_wdata, rdata, h_o, m_lanes, bus;
   logic ready, rvalid, cs_n, oe_n, we_n, h_oe, m_drive;
   int bad_count, n_compared;
   realtime we_fall, oe_rise;
   // Host wins the lanes when it drives, else the memory's lanes
   assign bus = h_oe ? h_o : m_lanes;
   srh_host dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_req(i_req),
      .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(ready),
      .o_rvalid(rvalid), .o_rdata(rdata), .o_mem_addr(m_addr),
      .o_mem_cs_n(cs_n), .o_mem_oe_n(oe_n), .o_mem_we_n(we_n),
      .o_shared_bus_lanes_o(h_o), .o_shared_bus_lanes_oe(h_oe),
      .i_shared_bus_lanes_i(bus));
   srh_mem_model mem (.i_addr(m_addr), .i_cs_n(cs_n), .i_oe_n(oe_n),
      .i_we_n(we_n), .i_lanes(bus), .i_slow(slow), .o_lanes(m_lanes),
      .o_drive(m_drive));
   task automatic check(string what, logic [16:0] exp, logic [16:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
         bad_count++;
      end
   endtask : check
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   // Bounded wait on a level seen at falling edges
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      while (s !== 1'b1) begin
         @(negedge i_mclk);
         n++;
         if (n > 20) begin
            bad_count++;
            wrap_up();
         end
      end
   endtask : wait_hi
   // One request held until taken; reads compare the answer
   task automatic xfer(logic we, logic [16:0] a, logic [7:0] d);
      @(negedge i_mclk);
      {i_req, i_we, i_addr, i_wdata} = {1'b1, we, a, d};
      wait_hi(ready);
      @(negedge i_mclk);
      i_req = 1'b0;
      check("mem addr", a, m_addr);
      check("select", 17'h0, {16'h0, cs_n});
      check("strobe", {16'h0, !we}, {16'h0, we_n});
      if (!we) begin
         wait_hi(rvalid);
         check("read data", {9'h0, d}, {9'h0, rdata});
      end
      wait_hi(ready);
   endtask : xfer
   // Sequencer idle after reset leaves memory deselected
   task automatic s_reset();
      check("idle pins", 17'h7, {14'h0, cs_n, oe_n, we_n});
      check("idle oe", 17'h0, {16'h0, h_oe});
   endtask : s_reset
   // Boundary addresses written then read back, prompt memory
   task automatic s_walk();
      xfer(1'b1, 17'h00000, 8'hA5);
      xfer(1'b1, 17'h1FFFF, 8'h3C);
      xfer(1'b1, 17'h0ABCD, 8'h0F);
      xfer(1'b0, 17'h1FFFF, 8'h3C);
      xfer(1'b0, 17'h00000, 8'hA5);
   endtask : s_walk
   // Memory at its slowest legal access
   task automatic s_slow();
      slow = 1'b1;
      xfer(1'b0, 17'h0ABCD, 8'h0F);
      xfer(1'b0, 17'h1FFFF, 8'h3C);
      slow = 1'b0;
   endtask : s_slow
   // A write offered while busy is dropped
   task automatic s_refuse();
      fork
         xfer(1'b0, 17'h00000, 8'hA5);
         begin
            repeat (3) @(negedge i_mclk);
            {i_req, i_we, i_addr, i_wdata} = {1'b1, 1'b1, 17'h0ABCD, 8'hEE};
            @(negedge i_mclk);
            i_req = 1'b0;
         end
      join
      xfer(1'b0, 17'h0ABCD, 8'h0F);
   endtask : s_refuse
   // Lane ownership, strobe and address checks on the pins
   always @(negedge i_mclk) begin
      if (i_resetn) begin
         if (h_oe && m_drive) check("lane contention", 0, 1);
         if (!cs_q && !cs_n) check("addr held", a_q, m_addr);
         if (!cs_n && !oe_n) check("strobe in read", 1, we_n);
      end
      cs_q <= cs_n;
      a_q <= m_addr;
   end
   always @(negedge we_n) we_fall = $realtime;
   always @(posedge h_oe) oe_rise = $realtime;
   // Strobe width and data setup at the end of each write
   always @(posedge we_n) begin
      if (i_resetn) begin
         check("strobe ns", 1, ($realtime - we_fall) >= (oe_n ? 8 : 9));
         check("setup ns", 1, h_oe && ($realtime - oe_rise) >= 5.0);
      end
   end
   initial begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end
   initial begin
      {i_resetn, i_req, i_we, slow, i_addr, i_wdata} = '0;
      {bad_count, n_compared} = '0;
      repeat (5) @(negedge i_mclk);
      i_resetn = 1'b1;
      s_reset();
      s_walk();
      s_slow();
      s_refuse();
      wrap_up();
   end
endmodule : srh_host_test
`default_nettype wire
